// file: hdl/cfg_resource_defs.vh
// Constants for the resource and pin configuration register bank
`ifndef CFG_RESOURCE_DEFS_VH
`define CFG_RESOURCE_DEFS_VH
// --------------------------------------------------------------
// Register indices
// --------------------------------------------------------------
`define IDX_UART_IRQ      8'h28
`define IDX_FLOPPY_IRQ    8'h29
`define IDX_IR_DMA        8'h2a
`define IDX_PIN_SEL_A     8'h2b
`define IDX_PIN_SEL_B     8'h2c
`define IDX_FLOPPY_RATE   8'h2d
`define IDX_MISC          8'h2e
`define IDX_SCI_IRQ       8'h31
// --------------------------------------------------------------
// Reset values
// --------------------------------------------------------------
`define RST_UART_IRQ_ON   8'h43
`define RST_FLOPPY_IRQ_ON 8'h62
`define RST_ZERO          8'h00
`define RST_PIN_SEL_B     8'h10
`define RST_MISC          8'h2e
// --------------------------------------------------------------
// Writable bit masks (reserved bits read zero)
// --------------------------------------------------------------
`define MASK_FULL         8'hff
`define MASK_PIN_SEL_B    8'hfc
`define MASK_FLOPPY_RATE  8'h3f
`define MASK_MISC         8'h3f
`define MASK_SCI_IRQ      8'hf4
// --------------------------------------------------------------
// Field positions
// --------------------------------------------------------------
`define PIN91_HI          7
`define PIN91_LO          5
`define CRC_APPEND_BIT    4
`define BANK_SEL_BIT      3
`define CLK_SEL_BIT       2
`define PREC_A_BIT        2
`define PREC_B_BIT        5
`define PNF_EN_BIT        0
`define WIDE_DEC_BIT      1
`define INV_RD_BIT        2
`define BURST_DIS_BIT     3
`define DOUBLER_BIT       4
`define IRQ_MODE_BIT      2
// --------------------------------------------------------------
// Pin function codes (3-bit binary, shared by all pins)
// --------------------------------------------------------------
`define F_IRQ             3'd0
`define F_DRQ             3'd1
`define F_INFRARED_SELECT_TWO           3'd2
`define F_INFRARED_SELECT_ONE           3'd3
`define F_SHARED          3'd4
`define F_DACK            3'd5
`define F_OTHER           3'd6
`define F_RESV            3'd7
// --------------------------------------------------------------
// Floppy data rate codes
// --------------------------------------------------------------
`define RATE_CODE_1M      2'b11
`define RATE_CODE_500     2'b00
`define RATE_CODE_250     2'b10
`define RATE_CODE_300     2'b01
`define RATE_MFM_1M       3'd0
`define RATE_MFM_500      3'd1
`define RATE_MFM_300      3'd2
`define RATE_MFM_250      3'd3
`define RATE_MFM_2M       3'd4
`define RATE_TBL_00       2'b00
`define RATE_TBL_01       2'b01
`define RATE_TBL_10       2'b10
`define SCI_LINES         8
`endif

// file: hdl/rate_table_lookup.v
// Floppy data rate lookup for one drive
`include "cfg_resource_defs.vh"
module rate_table_lookup (
	// Inputs
	input  wire [1:0] table_sel,
	input  wire [1:0] rate_sel,
	// Result
	output reg  [2:0] mfm_rate,
	output reg        fm_valid
);
	// --------------------------------------------------------------
	// Table
	// --------------------------------------------------------------
	// rate table decode
	always @* begin
		mfm_rate = `RATE_MFM_500;
		fm_valid = 1'b1;
		case (rate_sel)
		`RATE_CODE_1M: begin
			mfm_rate = `RATE_MFM_1M;
			fm_valid = 1'b0;
		end
		`RATE_CODE_500: mfm_rate = `RATE_MFM_500;
		`RATE_CODE_250: mfm_rate = `RATE_MFM_250;
		default: begin
			case (table_sel)
			`RATE_TBL_00: mfm_rate = `RATE_MFM_300;
			`RATE_TBL_01: mfm_rate = `RATE_MFM_500;
			`RATE_TBL_10: begin
				mfm_rate = `RATE_MFM_2M;
				fm_valid = 1'b0;
			end
			// Table 11 undefined; treat like table 01
			default: mfm_rate = `RATE_MFM_500;
			endcase
		end
		endcase
	end
endmodule // rate_table_lookup

// file: hdl/resource_pin_config.v
// Resource routing and pin function configuration register bank
// Notes on behaviour
// - Index then data port reach registers
// - UART routing register, strap reset 43h
// - Floppy routing resets 62h or 00h
// - Floppy and external input IRQ fields
// - Infrared transmit and receive DMA fields
// - Pin 1 function, clock in serial
// - Pin 2 chip select or address 11
// - Pin 3 function select
// - Pin 93 function, printer-not-floppy override
// - Pin 91 function, serial IRQ pin
// - Bank bit picks select0 or receive
// - CRC append enable for receiver
// - Serial B bank select enable
// - Input clock 24 or 48 MHz
// - Rate table per drive
// - Fixed rate codes and FM rates
// - Per drive precompensation disable
// - Misc register, printer-not-floppy enable
// - Wide address decode, auto infrared
// - Floppy read data inversion
// - Burst disable and doubler variant
// - SCI line routing, others floated
// - Serial mode floats lines, uses frame
// - Interrupt mode select bit
`include "cfg_resource_defs.vh"
module resource_pin_config #(
	parameter LINES = `SCI_LINES
) (
	// Clock and reset
	input  wire             mclk,
	input  wire             rst,
	// Strap, caught after reset release
	input  wire             power_on_strap,
	// Configuration ports, valid in extended function mode
	input  wire             ext_mode_active,
	input  wire             config_index_port_wr,
	input  wire             config_data_port_wr,
	input  wire             config_data_port_rd,
	input  wire [7:0]       host_wdata,
	output reg  [7:0]       config_data_port,
	output reg              rdata_hit,
	// Bank 7 infrared selector bit
	input  wire             ir_select_zero_mode,
	// Floppy rate inputs and read data
	input  wire             rate_select_high,
	input  wire             rate_select_low,
	input  wire             floppy_read_data,
	// SCI source
	input  wire             sci_level,
	// Resource routing fields
	output reg  [3:0]       serial_a_irq_select,
	output reg  [3:0]       serial_b_irq_select,
	output reg  [3:0]       floppy_irq_select,
	output reg  [3:0]       ext_irq_in_select,
	output reg  [3:0]       infrared_tx_dma_select,
	output reg  [3:0]       infrared_rx_dma_select,
	output reg  [3:0]       sci_frame_select,
	output reg              sci_serial_request,
	// Pin functions, codes from the header
	output reg  [2:0]       pin1_function,
	output reg              pin2_address_mode,
	output reg  [2:0]       pin3_function,
	output reg  [2:0]       pin93_function,
	output reg  [2:0]       pin91_function,
	output reg              pin_select_zero_drive,
	// Feature controls
	output reg              rx_crc_append_enable,
	output reg              serial_b_bank_select_enable,
	output reg              input_clock_freq_select,
	output reg              wide_address_decode,
	output reg              serial_b_auto_infrared,
	output reg              floppy_burst_enable,
	output reg              clock_doubler_variant,
	output reg              interrupt_mode_select,
	output reg              drive_a_precomp_enable,
	output reg              drive_b_precomp_enable,
	output reg  [2:0]       drive_a_mfm_rate,
	output reg              drive_a_fm_valid,
	output reg  [2:0]       drive_b_mfm_rate,
	output reg              drive_b_fm_valid,
	output reg              floppy_data_used,
	// SCI parallel lines
	output reg  [LINES-1:0] sci_line_out,
	output reg  [LINES-1:0] sci_line_oe
);
	// --------------------------------------------------------------
	// Registers
	// --------------------------------------------------------------
	reg  [7:0]       index_q;
	reg  [7:0]       uart_irq_routing_q;
	reg  [7:0]       floppy_extin_irq_routing_q;
	reg  [7:0]       infrared_dma_routing_q;
	reg  [7:0]       pin_function_select_a_q;
	reg  [7:0]       pin_function_select_b_q;
	reg  [7:0]       floppy_rate_precomp_q;
	reg  [7:0]       misc_feature_control_q;
	reg  [7:0]       sci_irq_routing_q;
	reg              strap_done_q;
	reg  [7:0]       rd_d;
	reg              hit_d;
	wire             wr_en;
	wire             serial_mode;
	wire             pnf_en;
	wire [2:0]       rate_a;
	wire [2:0]       rate_b;
	wire             fm_a;
	wire             fm_b;
	wire [LINES-1:0] line_o;
	wire [LINES-1:0] line_e;
	reg  [2:0]       p1_d;
	reg  [2:0]       p3_d;
	reg  [2:0]       p93_d;
	reg  [2:0]       p91_d;

	assign wr_en       = ext_mode_active & config_data_port_wr;
	assign serial_mode = sci_irq_routing_q[`IRQ_MODE_BIT];
	assign pnf_en      = misc_feature_control_q[`PNF_EN_BIT];

	// --------------------------------------------------------------
	// Index and register storage
	// --------------------------------------------------------------
	// Strap defaults load one cycle after release, since an async
	// reset may only load constants.
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			index_q                    <= `RST_ZERO;
			strap_done_q               <= 1'b0;
			uart_irq_routing_q         <= `RST_ZERO;
			floppy_extin_irq_routing_q <= `RST_ZERO;
			infrared_dma_routing_q     <= `RST_ZERO;
			pin_function_select_a_q    <= `RST_ZERO;
			pin_function_select_b_q    <= `RST_PIN_SEL_B;
			floppy_rate_precomp_q      <= `RST_ZERO;
			misc_feature_control_q     <= `RST_MISC & `MASK_MISC;
			sci_irq_routing_q          <= `RST_ZERO;
		end else begin
			strap_done_q <= 1'b1;
			if (ext_mode_active && config_index_port_wr)
				index_q <= host_wdata;
			if (!strap_done_q && power_on_strap) begin
				uart_irq_routing_q         <= `RST_UART_IRQ_ON;
				floppy_extin_irq_routing_q <= `RST_FLOPPY_IRQ_ON;
			end else if (wr_en) begin
				case (index_q)
				`IDX_UART_IRQ:
					uart_irq_routing_q <= host_wdata;
				`IDX_FLOPPY_IRQ:
					floppy_extin_irq_routing_q <= host_wdata;
				`IDX_IR_DMA:
					infrared_dma_routing_q <= host_wdata;
				`IDX_PIN_SEL_A:
					pin_function_select_a_q <= host_wdata;
				`IDX_PIN_SEL_B:
					pin_function_select_b_q <=
						host_wdata & `MASK_PIN_SEL_B;
				`IDX_FLOPPY_RATE:
					floppy_rate_precomp_q <=
						host_wdata & `MASK_FLOPPY_RATE;
				`IDX_MISC:
					misc_feature_control_q <=
						host_wdata & `MASK_MISC;
				`IDX_SCI_IRQ:
					sci_irq_routing_q <=
						host_wdata & `MASK_SCI_IRQ;
				default: ;
				endcase
			end
		end
	end

	// --------------------------------------------------------------
	// Read mux
	// --------------------------------------------------------------
	// data port read select
	always @* begin
		hit_d = 1'b1;
		case (index_q)
		`IDX_UART_IRQ:    rd_d = uart_irq_routing_q;
		`IDX_FLOPPY_IRQ:  rd_d = floppy_extin_irq_routing_q;
		`IDX_IR_DMA:      rd_d = infrared_dma_routing_q;
		`IDX_PIN_SEL_A:   rd_d = pin_function_select_a_q;
		`IDX_PIN_SEL_B:   rd_d = pin_function_select_b_q;
		`IDX_FLOPPY_RATE: rd_d = floppy_rate_precomp_q;
		`IDX_MISC:        rd_d = misc_feature_control_q;
		`IDX_SCI_IRQ:     rd_d = sci_irq_routing_q;
		default: begin
			rd_d  = `RST_ZERO;
			hit_d = 1'b0;
		end
		endcase
		if (!(ext_mode_active && config_data_port_rd)) begin
			rd_d  = `RST_ZERO;
			hit_d = 1'b0;
		end
	end

	// --------------------------------------------------------------
	// Pin function decode
	// --------------------------------------------------------------
	always @* begin
		case (pin_function_select_a_q[7:6])
		2'b00:   p1_d = `F_IRQ;
		2'b10:   p1_d = `F_DRQ;
		2'b11:   p1_d = `F_INFRARED_SELECT_TWO;
		default: p1_d = `F_RESV;
		endcase
		if (serial_mode)
			p1_d = `F_OTHER;
		case (pin_function_select_a_q[3:2])
		2'b00:   p3_d = `F_OTHER;
		2'b01:   p3_d = `F_DACK;
		2'b10:   p3_d = `F_INFRARED_SELECT_ONE;
		default: p3_d = `F_SHARED;
		endcase
		case (pin_function_select_a_q[1:0])
		2'b00:   p93_d = `F_IRQ;
		2'b01:   p93_d = `F_DRQ;
		2'b10:   p93_d = `F_INFRARED_SELECT_TWO;
		default: p93_d = `F_SHARED;
		endcase
		if (pnf_en)
			p93_d = `F_OTHER;
		case (pin_function_select_b_q[`PIN91_HI:`PIN91_LO])
		3'b000:  p91_d = `F_IRQ;
		3'b010:  p91_d = `F_INFRARED_SELECT_TWO;
		3'b100:  p91_d = `F_DACK;
		default: p91_d = `F_RESV;
		endcase
		if (serial_mode)
			p91_d = `F_OTHER;
	end

	// --------------------------------------------------------------
	// Helpers
	// --------------------------------------------------------------
	rate_table_lookup u_rate_a (
		.table_sel (floppy_rate_precomp_q[1:0]),
		.rate_sel  ({rate_select_high, rate_select_low}),
		.mfm_rate  (rate_a),
		.fm_valid  (fm_a)
	);

	rate_table_lookup u_rate_b (
		.table_sel (floppy_rate_precomp_q[4:3]),
		.rate_sel  ({rate_select_high, rate_select_low}),
		.mfm_rate  (rate_b),
		.fm_valid  (fm_b)
	);

	sci_line_router #(.LINES(LINES)) u_sci (
		.line_sel    (sci_irq_routing_q[7:4]),
		.serial_mode (serial_mode),
		.sci_level   (sci_level),
		.line_out    (line_o),
		.line_oe     (line_e)
	);

	// --------------------------------------------------------------
	// Registered outputs
	// --------------------------------------------------------------
	// All outputs are registered, so they trail the register bank by
	// one cycle; a trade of latency for clean timing at the pins.
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			config_data_port            <= `RST_ZERO;
			rdata_hit                   <= 1'b0;
			serial_a_irq_select         <= 4'h0;
			serial_b_irq_select         <= 4'h0;
			floppy_irq_select           <= 4'h0;
			ext_irq_in_select           <= 4'h0;
			infrared_tx_dma_select      <= 4'h0;
			infrared_rx_dma_select      <= 4'h0;
			sci_frame_select            <= 4'h0;
			sci_serial_request          <= 1'b0;
			pin1_function               <= `F_IRQ;
			pin2_address_mode           <= 1'b0;
			pin3_function               <= `F_OTHER;
			pin93_function              <= `F_IRQ;
			pin91_function              <= `F_IRQ;
			pin_select_zero_drive       <= 1'b0;
			rx_crc_append_enable        <= 1'b1;
			serial_b_bank_select_enable <= 1'b0;
			input_clock_freq_select     <= 1'b0;
			wide_address_decode         <= 1'b1;
			serial_b_auto_infrared      <= 1'b1;
			floppy_burst_enable         <= 1'b1;
			clock_doubler_variant       <= 1'b0;
			interrupt_mode_select       <= 1'b0;
			drive_a_precomp_enable      <= 1'b1;
			drive_b_precomp_enable      <= 1'b1;
			drive_a_mfm_rate            <= `RATE_MFM_500;
			drive_a_fm_valid            <= 1'b1;
			drive_b_mfm_rate            <= `RATE_MFM_500;
			drive_b_fm_valid            <= 1'b1;
			floppy_data_used            <= 1'b0;
			sci_line_out                <= {LINES{1'b0}};
			sci_line_oe                 <= {LINES{1'b0}};
		end else begin
			config_data_port <= rd_d;
			rdata_hit        <= hit_d;
			serial_a_irq_select <= uart_irq_routing_q[7:4];
			serial_b_irq_select <= uart_irq_routing_q[3:0];
			floppy_irq_select <= floppy_extin_irq_routing_q[7:4];
			ext_irq_in_select <= floppy_extin_irq_routing_q[3:0];
			infrared_tx_dma_select <= infrared_dma_routing_q[7:4];
			infrared_rx_dma_select <= infrared_dma_routing_q[3:0];
			sci_frame_select   <= serial_mode ?
				sci_irq_routing_q[7:4] : 4'h0;
			sci_serial_request <= serial_mode & sci_level;
			pin1_function      <= p1_d;
			pin2_address_mode  <=
				(pin_function_select_a_q[5:4] == 2'b01);
			pin3_function      <= p3_d;
			pin93_function     <= p93_d;
			pin91_function     <= p91_d;
			pin_select_zero_drive <= ir_select_zero_mode;
			rx_crc_append_enable <=
				pin_function_select_b_q[`CRC_APPEND_BIT];
			serial_b_bank_select_enable <=
				pin_function_select_b_q[`BANK_SEL_BIT];
			input_clock_freq_select <=
				pin_function_select_b_q[`CLK_SEL_BIT];
			wide_address_decode    <=
				~misc_feature_control_q[`WIDE_DEC_BIT];
			serial_b_auto_infrared <=
				~misc_feature_control_q[`WIDE_DEC_BIT];
			floppy_burst_enable   <=
				~misc_feature_control_q[`BURST_DIS_BIT];
			clock_doubler_variant <=
				misc_feature_control_q[`DOUBLER_BIT];
			interrupt_mode_select <= serial_mode;
			drive_a_precomp_enable <=
				~floppy_rate_precomp_q[`PREC_A_BIT];
			drive_b_precomp_enable <=
				~floppy_rate_precomp_q[`PREC_B_BIT];
			drive_a_mfm_rate <= rate_a;
			drive_a_fm_valid <= fm_a;
			drive_b_mfm_rate <= rate_b;
			drive_b_fm_valid <= fm_b;
			floppy_data_used <= floppy_read_data ^
				misc_feature_control_q[`INV_RD_BIT];
			sci_line_out <= line_o;
			sci_line_oe  <= line_e;
		end
	end
endmodule // resource_pin_config

// file: hdl/sci_line_router.v
// Routes the SCI interrupt onto one of eight parallel lines
`include "cfg_resource_defs.vh"
module sci_line_router #(
	parameter LINES = `SCI_LINES
) (
	// Control
	input  wire [3:0]       line_sel,
	input  wire             serial_mode,
	input  wire             sci_level,
	// Lines
	output reg  [LINES-1:0] line_out,
	output reg  [LINES-1:0] line_oe
);
	integer i;
	always @* begin
		line_out = {LINES{1'b0}};
		line_oe  = {LINES{1'b0}};
		for (i = 0; i < LINES; i = i + 1) begin
			if (!serial_mode && line_sel == i + 1) begin
				line_out[i] = sci_level;
				line_oe[i]  = 1'b1;
			end
		end
	end
endmodule // sci_line_router

// file: test/host_cfg_model.sv
// Host model driving the configuration index and data ports
module host_cfg_model (
	// Clock
	input  wire logic       mclk,
	// Port strobes
	output logic            ext_mode_active,
	output logic            config_index_port_wr,
	output logic            config_data_port_wr,
	output logic            config_data_port_rd,
	output logic [7:0]      host_wdata,
	// Read answer
	input  wire logic [7:0] config_data_port,
	input  wire logic       rdata_hit
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		ext_mode_active = 1'b1;
		config_index_port_wr = 1'b0;
		config_data_port_wr = 1'b0;
		config_data_port_rd = 1'b0;
		host_wdata = 8'h00;
	end
	// index write, then data write or read
	task automatic acc(input logic [7:0] a, input logic [7:0] d,
			input logic rd, output logic [7:0] q, output logic h);
		@(posedge mclk);
		config_index_port_wr <= 1'b1;
		host_wdata <= a;
		@(posedge mclk);
		config_index_port_wr <= 1'b0;
		config_data_port_wr <= !rd;
		config_data_port_rd <= rd;
		host_wdata <= d;
		@(posedge mclk);
		config_data_port_wr <= 1'b0;
		config_data_port_rd <= 1'b0;
		// Released bus flips, so a stale byte never looks valid
		host_wdata <= ~d;
		#1;
		q = config_data_port;
		h = rdata_hit;
	endtask
	task automatic set_ext(input logic e);
		@(posedge mclk);
		ext_mode_active <= e;
	endtask
endmodule // host_cfg_model

// file: test/resource_pin_checker.sv
// Port assertions for the resource and pin configuration bank
`include "cfg_resource_defs.vh"
module resource_pin_checker #(
	parameter LINES = `SCI_LINES
) (
	// Clock and reset
	input wire logic             mclk,
	input wire logic             rst,
	// Host ports
	input wire logic             ext_mode_active,
	input wire logic             config_index_port_wr,
	input wire logic             config_data_port_wr,
	input wire logic             config_data_port_rd,
	input wire logic [7:0]       host_wdata,
	input wire logic [7:0]       config_data_port,
	input wire logic             rdata_hit,
	// Watched outputs and the SCI source input
	input wire logic             sci_level,
	input wire logic             interrupt_mode_select,
	input wire logic [LINES-1:0] sci_line_oe,
	input wire logic [3:0]       sci_frame_select,
	input wire logic             sci_serial_request,
	input wire logic [2:0]       pin1_function,
	input wire logic [2:0]       pin91_function,
	input wire logic             wide_address_decode,
	input wire logic             serial_b_auto_infrared
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] idx_q;
	logic       mapped;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	// --------------------------------------------------------------
	// Index shadow
	// --------------------------------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			idx_q <= 8'h00;
		else if (ext_mode_active && config_index_port_wr)
			idx_q <= host_wdata;
	end
	assign mapped = idx_q inside {`IDX_UART_IRQ, `IDX_FLOPPY_IRQ,
		`IDX_IR_DMA, `IDX_PIN_SEL_A, `IDX_PIN_SEL_B, `IDX_FLOPPY_RATE,
		`IDX_MISC, `IDX_SCI_IRQ};
	sequence pin_b_write;
		ext_mode_active && config_index_port_wr
			&& host_wdata == `IDX_PIN_SEL_B ##1
		ext_mode_active && config_data_port_wr;
	endsequence
	sequence pin_b_read;
		ext_mode_active && config_index_port_wr
			&& host_wdata == `IDX_PIN_SEL_B ##1
		ext_mode_active && config_data_port_rd;
	endsequence
	// --------------------------------------------------------------
	// Assertions
	// --------------------------------------------------------------
	read_hit_a: assert property (
		ext_mode_active && config_data_port_rd && mapped |=> rdata_hit)
		else $error("mapped read without hit");
	read_miss_a: assert property (
		ext_mode_active && config_data_port_rd && !mapped
		|=> config_data_port == 8'h00 && !rdata_hit)
		else $error("unmapped read returned data");
	read_idle_a: assert property (
		!(ext_mode_active && config_data_port_rd)
		|=> config_data_port == 8'h00 && !rdata_hit)
		else $error("read data without a read");
	pin_readback_a: assert property (
		pin_b_write ##2 pin_b_read
		|=> config_data_port == ($past(host_wdata, 4) & 8'hfc))
		else $error("pin select readback wrong");
	sci_onehot_a: assert property (
		$onehot0(sci_line_oe) && (!interrupt_mode_select
		|| sci_line_oe == '0))
		else $error("more than one line driven");
	frame_gate_a: assert property (
		!interrupt_mode_select |-> sci_frame_select == 4'h0)
		else $error("frame period outside serial mode");
	serial_req_a: assert property (
		sci_serial_request |-> interrupt_mode_select && $past(sci_level))
		else $error("serial request without cause");
	serial_pins_a: assert property (
		interrupt_mode_select
		|-> pin1_function == `F_OTHER && pin91_function == `F_OTHER)
		else $error("pins not clock and serial irq");
	wide_pair_a: assert property (
		wide_address_decode == serial_b_auto_infrared)
		else $error("auto infrared differs from decode");
endmodule // resource_pin_checker

// file: test/tb_resource_pin_config.sv
// Testbench for the resource and pin configuration bank
`include "cfg_resource_defs.vh"
module tb_resource_pin_config;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LINES = `SCI_LINES;
	logic mclk = 0, rst = 1, power_on_strap = 1, ir_select_zero_mode = 0;
	logic rate_select_high = 0, rate_select_low = 0, floppy_read_data = 0;
	logic sci_level = 0, ext_mode_active, config_index_port_wr;
	logic config_data_port_wr, config_data_port_rd, rdata_hit;
	logic [7:0] host_wdata, config_data_port;
	logic [3:0] serial_a_irq_select, serial_b_irq_select, floppy_irq_select;
	logic [3:0] ext_irq_in_select, infrared_tx_dma_select;
	logic [3:0] infrared_rx_dma_select, sci_frame_select;
	logic sci_serial_request, pin2_address_mode, pin_select_zero_drive;
	logic [2:0] pin1_function, pin3_function, pin93_function, pin91_function;
	logic rx_crc_append_enable, serial_b_bank_select_enable;
	logic input_clock_freq_select, wide_address_decode, floppy_burst_enable;
	logic serial_b_auto_infrared, clock_doubler_variant;
	logic interrupt_mode_select, drive_a_precomp_enable;
	logic drive_b_precomp_enable, drive_a_fm_valid, drive_b_fm_valid;
	logic [2:0] drive_a_mfm_rate, drive_b_mfm_rate;
	logic floppy_data_used;
	logic [LINES-1:0] sci_line_out, sci_line_oe;
	int n_mismatch = 0, check_count = 0;
	logic [7:0] idx_t [8] = '{8'h28,8'h29,8'h2a,8'h2b,8'h2c,8'h2d,8'h2e,8'h31};
	logic [7:0] rst_t [8] = '{8'h43,8'h62,8'h00,8'h00,8'h10,8'h00,8'h2e,8'h00};
	logic [7:0] msk_t [8] = '{8'hff,8'hff,8'hff,8'hff,8'hfc,8'h3f,8'h3f,8'hf4};
	logic [2:0] p1 [4] = '{0, 7, 1, 2};
	logic [2:0] p3 [4] = '{6, 5, 3, 4};
	logic [2:0] p93 [4] = '{0, 1, 2, 4};
	logic [2:0] p91 [5] = '{0, 7, 2, 7, 5};
	logic [7:0] v;
	always #2 mclk = ~mclk;
	resource_pin_config #(.LINES(LINES)) u_resource_pin_config (.*);
	host_cfg_model u_host_cfg_model (.*);
	// --------------------------------------------------------------
	// Tasks
	// --------------------------------------------------------------
	task automatic chk(input string nm, input logic [7:0] e,
			input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chkb(input string nm, input logic e, input logic g);
		chk(nm, {7'h00, e}, {7'h00, g});
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e,
			input logic h);
		logic [7:0] d;
		logic       hit;
		u_host_cfg_model.acc(a, 8'h00, 1'b1, d, hit);
		chk("read data", e, d);
		chkb("read hit", h, hit);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		logic       h;
		u_host_cfg_model.acc(a, d, 1'b0, q, h);
	endtask
	task automatic settle();
		repeat (2) @(posedge mclk);
		#1;
	endtask
	task automatic do_reset(input logic s);
		@(posedge mclk);
		rst <= 1'b1;
		power_on_strap <= s;
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		repeat (2) @(posedge mclk);
	endtask
	task automatic tdone(input string nm);
		$display("test %s done", nm);
	endtask
	function automatic logic [2:0] rate_exp(int t, int r);
		case (r)
			3: return 3'd0;
			0: return 3'd1;
			2: return 3'd3;
			default: return (t == 0) ? 3'd2 : (t == 1) ? 3'd1 : 3'd4;
		endcase
	endfunction
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// --------------------------------------------------------------
	// Tests
	// --------------------------------------------------------------
	initial begin
		do_reset(1'b1);
		foreach (idx_t[i]) rd_chk(idx_t[i], rst_t[i], 1'b1);
		tdone("reset values");
		foreach (idx_t[i]) begin
			wr(idx_t[i], 8'hff);
			rd_chk(idx_t[i], msk_t[i], 1'b1);
			wr(idx_t[i], 8'h00);
			rd_chk(idx_t[i], 8'h00, 1'b1);
		end
		rd_chk(8'h30, 8'h00, 1'b0);
		u_host_cfg_model.set_ext(1'b0);
		wr(8'h28, 8'hff);
		u_host_cfg_model.set_ext(1'b1);
		rd_chk(8'h28, 8'h00, 1'b1);
		tdone("access and masks");
		wr(8'h28, 8'ha5);
		wr(8'h29, 8'h3c);
		wr(8'h2a, 8'h12);
		settle();
		chk("uart a", 8'h0a, {4'h0, serial_a_irq_select});
		chk("uart b", 8'h05, {4'h0, serial_b_irq_select});
		chk("floppy irq", 8'h03, {4'h0, floppy_irq_select});
		chk("ext irq", 8'h0c, {4'h0, ext_irq_in_select});
		chk("ir tx", 8'h01, {4'h0, infrared_tx_dma_select});
		chk("ir rx", 8'h02, {4'h0, infrared_rx_dma_select});
		floppy_read_data <= 1'b1;
		for (int j = 0; j < 2; j++) begin
			v = j ? 8'h00 : 8'h1f;
			wr(8'h2c, v & 8'h1c);
			wr(8'h2e, v);
			settle();
			chkb("crc", v[4], rx_crc_append_enable);
			chkb("bank", v[3], serial_b_bank_select_enable);
			chkb("clk", v[2], input_clock_freq_select);
			chkb("wide", !v[1], wide_address_decode);
			chkb("auto ir", !v[1], serial_b_auto_infrared);
			chkb("rdata", !v[2], floppy_data_used);
			chkb("burst", !v[3], floppy_burst_enable);
			chkb("doubler", v[4], clock_doubler_variant);
		end
		tdone("routing and features");
		for (int t = 0; t < 3; t++) begin
			wr(8'h2d, {2'b00, t[0], t[1:0], t[0], t[1:0]});
			for (int r = 0; r < 4; r++) begin
				@(posedge mclk);
				rate_select_high <= r[1];
				rate_select_low <= r[0];
				settle();
				chk("rate a", {5'h00, rate_exp(t, r)}, {5'h00, drive_a_mfm_rate});
				chk("rate b", {5'h00, rate_exp(t, r)}, {5'h00, drive_b_mfm_rate});
				chkb("fm a", !(rate_exp(t, r) inside {0, 4}), drive_a_fm_valid);
				chkb("fm b", !(rate_exp(t, r) inside {0, 4}), drive_b_fm_valid);
				chkb("precomp", !t[0], drive_a_precomp_enable);
				chkb("precomp b", !t[0], drive_b_precomp_enable);
			end
		end
		tdone("rate table");
		for (int k = 0; k < 4; k++) begin
			wr(8'h2b, k * 8'h55);
			@(posedge mclk);
			ir_select_zero_mode <= k[0];
			settle();
			chk("pin1", {5'h00, p1[k]}, {5'h00, pin1_function});
			chkb("pin2", k == 1, pin2_address_mode);
			chk("pin3", {5'h00, p3[k]}, {5'h00, pin3_function});
			chk("pin93", {5'h00, p93[k]}, {5'h00, pin93_function});
			chkb("sel0", k[0], pin_select_zero_drive);
		end
		wr(8'h2e, 8'h01);
		settle();
		chk("pin93 pnf", {5'h00, `F_OTHER}, {5'h00, pin93_function});
		for (int c = 0; c < 5; c++) begin
			wr(8'h2c, c << 5);
			settle();
			chk("pin91", {5'h00, p91[c]}, {5'h00, pin91_function});
		end
		tdone("pin functions");
		@(posedge mclk);
		sci_level <= 1'b1;
		for (int s = 0; s < 9; s++) begin
			wr(8'h31, s << 4);
			settle();
			chk("sci oe", (s == 0) ? 8'h00 : 8'h01 << (s - 1), 8'(sci_line_oe));
			chk("sci out", (s == 0) ? 8'h00 : 8'h01 << (s - 1), 8'(sci_line_out));
		end
		wr(8'h31, 8'h54);
		settle();
		chkb("irq mode", 1'b1, interrupt_mode_select);
		chk("sci float", 8'h00, 8'(sci_line_oe));
		chk("frame", 8'h05, {4'h0, sci_frame_select});
		chkb("serial req", 1'b1, sci_serial_request);
		chk("pin1 clk", {5'h00, `F_OTHER}, {5'h00, pin1_function});
		tdone("sci routing");
		do_reset(1'b0);
		rd_chk(8'h28, 8'h00, 1'b1);
		rd_chk(8'h29, 8'h00, 1'b1);
		tdone("strap low");
		wrap_up();
	end
	initial begin
		repeat (20000) @(posedge mclk);
		n_mismatch++;
		wrap_up();
	end
endmodule // tb_resource_pin_config
bind resource_pin_config resource_pin_checker #(.LINES(LINES))
	u_resource_pin_checker (.*);
